// [design/osc_defs.vh]
`ifndef OSC_DEFS_VH
`define OSC_DEFS_VH

// ----------------------------------------------------------------------------
// APB register byte offsets
// ----------------------------------------------------------------------------
`define OSC_ADR_DIAG_SETUP   8'h00
`define OSC_ADR_OUT_SETUP    8'h04
`define OSC_ADR_IRQ_STATUS   8'h08
`define OSC_ADR_IRQ_ENABLE   8'h0C
`define OSC_ADR_IRQ_CLEAR    8'h10
`define OSC_ADR_LIVE_STATE   8'h14

// ----------------------------------------------------------------------------
// Setup word layout
// ----------------------------------------------------------------------------
`define OSC_SETUP_W          16
`define OSC_DIAG_WMASK       16'h30FF
`define OSC_OUT_WMASK        16'h7FFF
`define OSC_SETUP_RST        16'h0000
`define OSC_D_CH2_AMP        13
`define OSC_D_SENT           12
`define OSC_D_OV_GND         7
`define OSC_D_BURN_IN        6
`define OSC_D_NORMAL         5
`define OSC_D_START_ZERO     4
`define OSC_D_OV_OFF         3
`define OSC_D_LATCH          2
`define OSC_D_HIDE_ERR       1
`define OSC_D_LOCK           0
`define OSC_O_TYPE_HI        14
`define OSC_O_TYPE_LO        13
`define OSC_O_H1             12
`define OSC_O_TICK_HI        11
`define OSC_O_TICK_LO        8
`define OSC_O_OPEN_DRAIN     7
`define OSC_O_MODE_HI        6
`define OSC_O_MODE_LO        4
`define OSC_O_BIT3           3
`define OSC_O_RATE_HI        2
`define OSC_O_RATE_LO        0
`define OSC_MODE_PAUSE       3'h0
`define OSC_MODE_NO_PAUSE    3'h5

// ----------------------------------------------------------------------------
// Interrupt bits
// ----------------------------------------------------------------------------
`define OSC_IRQ_W            4
`define OSC_IRQ_OV           0
`define OSC_IRQ_DIAG         1
`define OSC_IRQ_FIRST        2
`define OSC_IRQ_LOCK         3

// ----------------------------------------------------------------------------
// Data codes
// ----------------------------------------------------------------------------
`define OSC_SENT_OV_CODE     12'hFFB
`define OSC_SENT_INIT_CODE   12'hFFE
`define OSC_SENT_ZERO        12'h000
`define OSC_PWM_OV_DUTY_PCT  8'h4B

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define OSC_CLK_NS           20
`define OSC_TICK_STEP_NS     250
`define OSC_TICK_BASE_STEPS  2
`define OSC_TICK_ACC_W       9
`define OSC_PWM_HZ_0         2000
`define OSC_PWM_HZ_1         1600
`define OSC_PWM_HZ_2         1000
`define OSC_PWM_HZ_3         800
`define OSC_PWM_HZ_4         500
`define OSC_PWM_HZ_5         400
`define OSC_PWM_HZ_6         250
`define OSC_PWM_HZ_7         200
`define OSC_SENT_HZ_0        8000
`define OSC_SENT_HZ_1        4000
`define OSC_SENT_HZ_2        2660
`define OSC_SENT_HZ_3        2000
`define OSC_SENT_HZ_4        1600
`define OSC_SENT_HZ_5        1000
`define OSC_SENT_HZ_6        800
`define OSC_SENT_HZ_7        500
`define OSC_PERIOD_W         20

`endif

// [design/osc_sync2.v]
`default_nettype none

module osc_sync2 #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // Asynchronous in, synchronous out
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule // osc_sync2

`default_nettype wire

// [design/osc_tick_gen.v]
`default_nettype none
`include "osc_defs.vh"

module osc_tick_gen (
    // Clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // Control
    input  wire       run,
    input  wire [3:0] tick_code,
    // One-cycle tick enable
    output wire       tick
);

    // Accumulate in half cycles so 12.5-cycle steps stay exact on average
    localparam integer HALF_INT = (2 * `OSC_TICK_STEP_NS) / `OSC_CLK_NS;
    localparam integer BASE_INT = `OSC_TICK_BASE_STEPS;
    localparam [`OSC_TICK_ACC_W-1:0] HALF_PER_STEP = HALF_INT[`OSC_TICK_ACC_W-1:0];
    localparam [`OSC_TICK_ACC_W-1:0] BASE_STEPS    = BASE_INT[`OSC_TICK_ACC_W-1:0];

    reg  [`OSC_TICK_ACC_W-1:0] acc_ff;
    reg                        tick_ff;
    wire [`OSC_TICK_ACC_W-1:0] thr;
    wire [`OSC_TICK_ACC_W-1:0] acc_sum;

    assign thr = HALF_PER_STEP *
        ({{(`OSC_TICK_ACC_W-4){1'b0}}, tick_code} + BASE_STEPS);
    assign acc_sum = acc_ff + 2'd2;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_ff  <= {`OSC_TICK_ACC_W{1'b0}};
            tick_ff <= 1'b0;
        end else if (!run) begin
            acc_ff  <= {`OSC_TICK_ACC_W{1'b0}};
            tick_ff <= 1'b0;
        end else if (acc_sum >= thr) begin
            acc_ff  <= acc_sum - thr;
            tick_ff <= 1'b1;
        end else begin
            acc_ff  <= acc_sum;
            tick_ff <= 1'b0;
        end
    end

    assign tick = tick_ff;

endmodule // osc_tick_gen

`default_nettype wire

// [design/osc_regs.v]
`default_nettype none
`include "osc_defs.vh"

module osc_regs #(
    parameter CLK_HZ = 50000000
) (
    // Clock and reset
    input  wire                      pclk,
    input  wire                      presetn,
    // APB slave
    input  wire                      psel,
    input  wire                      penable,
    input  wire                      pwrite,
    input  wire [7:0]                paddr,
    input  wire [31:0]               pwdata,
    output wire [31:0]               prdata,
    output wire                      pready,
    output wire                      pslverr,
    // Sensor pins and signal path
    input  wire                      ov_pin,
    input  wire                      diag_err_pin,
    input  wire                      sample_valid,
    input  wire [11:0]               position,
    input  wire [11:0]               temperature,
    input  wire [11:0]               amplitude,
    input  wire                      pwm_level,
    input  wire                      sent_level,
    // Encoder configuration
    output wire                      sent_sel,
    output wire                      normal_mode,
    output wire                      burn_in,
    output wire                      mem_locked,
    output wire [1:0]                sensor_type,
    output wire                      frame_h1,
    output wire                      six_nibbles,
    output wire                      pause_pulse,
    output wire                      pwm_start_rise,
    output wire                      sent_tick,
    output wire [`OSC_PERIOD_W-1:0]  frame_cycles,
    output wire [7:0]                pwm_force_duty,
    output wire [11:0]               fast_ch1,
    output wire [11:0]               fast_ch2,
    output wire                      status_err,
    // Output pin
    output wire                      out_o,
    output wire                      out_oe,
    // Interrupt
    output wire                      irq
);

    // ------------------------------------------------------------------------
    // Frame period lookup
    // ------------------------------------------------------------------------
    function [`OSC_PERIOD_W-1:0] period_of;
        input       is_sent;
        input [2:0] code;
        integer     hz;
        begin
            hz = 1;
            case (code)
                3'h0:    hz = is_sent ? `OSC_SENT_HZ_0 : `OSC_PWM_HZ_0;
                3'h1:    hz = is_sent ? `OSC_SENT_HZ_1 : `OSC_PWM_HZ_1;
                3'h2:    hz = is_sent ? `OSC_SENT_HZ_2 : `OSC_PWM_HZ_2;
                3'h3:    hz = is_sent ? `OSC_SENT_HZ_3 : `OSC_PWM_HZ_3;
                3'h4:    hz = is_sent ? `OSC_SENT_HZ_4 : `OSC_PWM_HZ_4;
                3'h5:    hz = is_sent ? `OSC_SENT_HZ_5 : `OSC_PWM_HZ_5;
                3'h6:    hz = is_sent ? `OSC_SENT_HZ_6 : `OSC_PWM_HZ_6;
                3'h7:    hz = is_sent ? `OSC_SENT_HZ_7 : `OSC_PWM_HZ_7;
                default: hz = 1;
            endcase
            hz        = CLK_HZ / hz;
            period_of = hz[`OSC_PERIOD_W-1:0];
        end
    endfunction

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg [`OSC_SETUP_W-1:0]   diag_function_setup_ff;
    reg [`OSC_SETUP_W-1:0]   output_format_setup_ff;
    reg [`OSC_IRQ_W-1:0]     irq_status_ff;
    reg [`OSC_IRQ_W-1:0]     irq_enable_ff;
    reg [31:0]               prdata_ff;
    reg                      pready_ff;
    reg                      pslverr_ff;
    reg                      diag_flag_ff;
    reg                      ov_prev_ff;
    reg                      diag_prev_ff;
    reg                      started_ff;
    reg                      irq_ff;
    reg                      out_o_ff;
    reg                      out_oe_ff;
    reg [11:0]               fast_ch1_ff;
    reg [11:0]               fast_ch2_ff;
    reg                      status_err_ff;
    reg [`OSC_PERIOD_W-1:0]  frame_cycles_ff;
    reg [7:0]                pwm_force_duty_ff;
    reg                      pause_pulse_ff;
    reg [31:0]               nxt_rdata;
    reg                      nxt_hit;
    reg [`OSC_IRQ_W-1:0]     nxt_irq_status;

    wire                     ov_sync;
    wire                     diag_sync;
    wire                     setup_phase;
    wire                     wr_strobe;
    wire                     lock_now;
    wire                     ov_active;
    wire                     err_visible;
    wire                     ov_to_gnd;
    wire                     ov_coded;
    wire                     drive_level;
    wire [`OSC_IRQ_W-1:0]    ev;
    wire [`OSC_PERIOD_W-1:0] period_pwm;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    osc_sync2 #(
        .WIDTH    (2)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({diag_err_pin, ov_pin}),
        .sync_out ({diag_sync, ov_sync})
    );

    // ------------------------------------------------------------------------
    // APB access
    // ------------------------------------------------------------------------
    assign setup_phase = psel & ~penable;
    assign wr_strobe   = psel & penable & pready_ff & pwrite;
    assign lock_now    = diag_function_setup_ff[`OSC_D_LOCK];

    always @* begin
        nxt_rdata = 32'h0000_0000;
        nxt_hit   = 1'b1;
        case (paddr)
            `OSC_ADR_DIAG_SETUP: nxt_rdata[`OSC_SETUP_W-1:0] = diag_function_setup_ff;
            `OSC_ADR_OUT_SETUP:  nxt_rdata[`OSC_SETUP_W-1:0] = output_format_setup_ff;
            `OSC_ADR_IRQ_STATUS: nxt_rdata[`OSC_IRQ_W-1:0]   = irq_status_ff;
            `OSC_ADR_IRQ_ENABLE: nxt_rdata[`OSC_IRQ_W-1:0]   = irq_enable_ff;
            `OSC_ADR_IRQ_CLEAR:  nxt_rdata = 32'h0000_0000;
            `OSC_ADR_LIVE_STATE: nxt_rdata[3:0] = {started_ff, diag_flag_ff,
                                                   ov_active, lock_now};
            default:             nxt_hit = 1'b0;
        endcase
    end

    // Zero wait: answer is prepared in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= setup_phase;
            pslverr_ff <= setup_phase & ~nxt_hit;
            if (setup_phase && !pwrite) begin
                prdata_ff <= nxt_rdata;
            end else if (setup_phase) begin
                prdata_ff <= 32'h0000_0000;
            end
        end
    end

    // Setup words; lock blocks any further change until reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            diag_function_setup_ff <= `OSC_SETUP_RST;
            output_format_setup_ff <= `OSC_SETUP_RST;
            irq_enable_ff          <= {`OSC_IRQ_W{1'b0}};
            pause_pulse_ff         <= 1'b1;
        end else if (wr_strobe) begin
            if (paddr == `OSC_ADR_DIAG_SETUP && !lock_now) begin
                // Reserved bits are kept at zero whatever is written
                diag_function_setup_ff <= pwdata[`OSC_SETUP_W-1:0]
                                          & `OSC_DIAG_WMASK;
            end
            if (paddr == `OSC_ADR_OUT_SETUP && !lock_now) begin
                output_format_setup_ff <= pwdata[`OSC_SETUP_W-1:0]
                                          & `OSC_OUT_WMASK;
                pause_pulse_ff         <= (pwdata[`OSC_O_MODE_HI:`OSC_O_MODE_LO]
                                           == `OSC_MODE_PAUSE);
            end
            if (paddr == `OSC_ADR_IRQ_ENABLE) begin
                irq_enable_ff <= pwdata[`OSC_IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Diagnosis and overvoltage
    // ------------------------------------------------------------------------
    assign ov_active   = ov_sync & ~diag_function_setup_ff[`OSC_D_OV_OFF];
    assign err_visible = diag_flag_ff & ~diag_function_setup_ff[`OSC_D_HIDE_ERR];
    assign ov_to_gnd   = ov_active & diag_function_setup_ff[`OSC_D_OV_GND];
    assign ov_coded    = ov_active & ~diag_function_setup_ff[`OSC_D_OV_GND];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            diag_flag_ff <= 1'b0;
            ov_prev_ff   <= 1'b0;
            diag_prev_ff <= 1'b0;
            started_ff   <= 1'b0;
        end else begin
            // Reset clears a latched flag; clearing the latch bit makes it follow the synchronised pin
            if (diag_function_setup_ff[`OSC_D_LATCH]) begin
                diag_flag_ff <= diag_flag_ff | diag_sync;
            end else begin
                diag_flag_ff <= diag_sync;
            end
            ov_prev_ff   <= ov_active;
            diag_prev_ff <= diag_sync;
            if (sample_valid) begin
                started_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interrupts: set beats a clear in the same cycle
    // ------------------------------------------------------------------------
    assign ev[`OSC_IRQ_OV]    = ov_active & ~ov_prev_ff;
    assign ev[`OSC_IRQ_DIAG]  = diag_sync & ~diag_prev_ff;
    assign ev[`OSC_IRQ_FIRST] = sample_valid & ~started_ff;
    assign ev[`OSC_IRQ_LOCK]  = wr_strobe & ~lock_now & (paddr == `OSC_ADR_DIAG_SETUP)
                                & pwdata[`OSC_D_LOCK];

    always @* begin
        nxt_irq_status = irq_status_ff;
        if (wr_strobe && paddr == `OSC_ADR_IRQ_CLEAR) begin
            nxt_irq_status = nxt_irq_status & ~pwdata[`OSC_IRQ_W-1:0];
        end
        nxt_irq_status = nxt_irq_status | ev;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_ff <= {`OSC_IRQ_W{1'b0}};
            irq_ff        <= 1'b0;
        end else begin
            irq_status_ff <= nxt_irq_status;
            irq_ff        <= |(nxt_irq_status & irq_enable_ff);
        end
    end

    // ------------------------------------------------------------------------
    // SENT tick
    // ------------------------------------------------------------------------
    osc_tick_gen u_tick (
        .pclk      (pclk),
        .presetn   (presetn),
        .run       (diag_function_setup_ff[`OSC_D_SENT]),
        .tick_code (output_format_setup_ff[`OSC_O_TICK_HI:`OSC_O_TICK_LO]),
        .tick      (sent_tick)
    );

    // ------------------------------------------------------------------------
    // Frame content and period
    // ------------------------------------------------------------------------
    assign period_pwm = period_of(1'b0, output_format_setup_ff[`OSC_O_RATE_HI:`OSC_O_RATE_LO]);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_ch1_ff       <= `OSC_SENT_ZERO;
            fast_ch2_ff       <= `OSC_SENT_ZERO;
            status_err_ff     <= 1'b0;
            frame_cycles_ff   <= {`OSC_PERIOD_W{1'b0}};
            pwm_force_duty_ff <= 8'h00;
        end else begin
            if (!started_ff) begin
                // No error bits while still starting up
                status_err_ff <= 1'b0;
                if (diag_function_setup_ff[`OSC_D_START_ZERO]) begin
                    fast_ch1_ff <= `OSC_SENT_ZERO;
                    fast_ch2_ff <= `OSC_SENT_ZERO;
                end else begin
                    fast_ch1_ff <= `OSC_SENT_INIT_CODE;
                    fast_ch2_ff <= `OSC_SENT_INIT_CODE;
                end
            end else if (ov_coded) begin
                fast_ch1_ff   <= `OSC_SENT_OV_CODE;
                fast_ch2_ff   <= `OSC_SENT_OV_CODE;
                status_err_ff <= 1'b1;
            end else begin
                fast_ch1_ff   <= position;
                status_err_ff <= err_visible;
                if (diag_function_setup_ff[`OSC_D_CH2_AMP]) begin
                    fast_ch2_ff <= amplitude;
                end else begin
                    fast_ch2_ff <= temperature;
                end
            end
            // Overvoltage PWM runs at half frequency with fixed duty
            if (!diag_function_setup_ff[`OSC_D_SENT] && ov_coded) begin
                frame_cycles_ff <= {period_pwm[`OSC_PERIOD_W-2:0], 1'b0};
                pwm_force_duty_ff <= `OSC_PWM_OV_DUTY_PCT;
            end else begin
                frame_cycles_ff <= period_of(diag_function_setup_ff[`OSC_D_SENT],
                    output_format_setup_ff[`OSC_O_RATE_HI:`OSC_O_RATE_LO]);
                pwm_force_duty_ff <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Output pin driver
    // ------------------------------------------------------------------------
    assign drive_level = diag_function_setup_ff[`OSC_D_SENT] ? sent_level
                                                              : pwm_level;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_o_ff  <= 1'b0;
            out_oe_ff <= 1'b0;
        end else if (ov_to_gnd) begin
            out_o_ff  <= 1'b0;
            out_oe_ff <= 1'b1;
        end else if (output_format_setup_ff[`OSC_O_OPEN_DRAIN]) begin
            // Open drain only pulls low; high comes from the pull-up
            out_o_ff  <= 1'b0;
            out_oe_ff <= ~drive_level;
        end else begin
            out_o_ff  <= drive_level;
            out_oe_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Ports
    // ------------------------------------------------------------------------
    assign prdata         = prdata_ff;
    assign pready         = pready_ff;
    assign pslverr        = pslverr_ff;
    assign sent_sel       = diag_function_setup_ff[`OSC_D_SENT];
    assign normal_mode    = diag_function_setup_ff[`OSC_D_NORMAL];
    assign burn_in        = diag_function_setup_ff[`OSC_D_BURN_IN];
    assign mem_locked     = diag_function_setup_ff[`OSC_D_LOCK];
    assign sensor_type    = output_format_setup_ff[`OSC_O_TYPE_HI:`OSC_O_TYPE_LO];
    assign frame_h1       = output_format_setup_ff[`OSC_O_H1];
    assign six_nibbles    = output_format_setup_ff[`OSC_O_BIT3];
    assign pwm_start_rise = output_format_setup_ff[`OSC_O_BIT3];
    assign pause_pulse    = pause_pulse_ff;
    assign frame_cycles   = frame_cycles_ff;
    assign pwm_force_duty = pwm_force_duty_ff;
    assign fast_ch1       = fast_ch1_ff;
    assign fast_ch2       = fast_ch2_ff;
    assign status_err     = status_err_ff;
    assign out_o          = out_o_ff;
    assign out_oe         = out_oe_ff;
    assign irq            = irq_ff;

endmodule // osc_regs

`default_nettype wire

// [tb/osc_rx_model.sv]
`default_nettype none
module osc_rx_model (input wire logic out_o, out_oe, output wire logic line);
    timeunit 1ns / 1ns;
    // Receiver pull-up: a released line reads high
    assign line = out_oe ? out_o : 1'b1;
endmodule // osc_rx_model
`default_nettype wire

// [tb/osc_regs_sva.sv]
`default_nettype none
module osc_chk (input wire logic pclk, presetn, psel, penable, pwrite, pready, sent_sel,
    input wire logic mem_locked, pause_pulse, sent_tick, input wire logic [7:0] paddr,
    input wire logic [7:0] pwm_force_duty, input wire logic [31:0] pwdata,
    input wire logic [1:0] sensor_type);
    timeunit 1ns / 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic wa = psel && penable && pready && pwrite && !mem_locked;
    property p_ans; psel && !penable |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("ready late");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready long");
    property p_mode; wa && paddr == 8'h00 |=> sent_sel == $past(pwdata[12]); endproperty
    a_mode: assert property (p_mode) else $error("mode bad");
    property p_type; wa && paddr == 8'h04 |=> sensor_type == $past(pwdata[14:13]); endproperty
    a_type: assert property (p_type) else $error("type bad");
    property p_pau; wa && paddr == 8'h04 |=> pause_pulse == ($past(pwdata[6:4]) == 3'h0);
    endproperty
    a_pau: assert property (p_pau) else $error("pause bad");
    property p_lock; mem_locked |=> mem_locked && $stable(sensor_type); endproperty
    a_lock: assert property (p_lock) else $error("lock lost");
    property p_tick; sent_tick |=> !sent_tick [*8]; endproperty
    a_tick: assert property (p_tick) else $error("tick early");
    property p_duty; pwm_force_duty != 8'h00 |-> pwm_force_duty == 8'h4B; endproperty
    a_duty: assert property (p_duty) else $error("duty bad");
endmodule // osc_chk
bind osc_regs osc_chk u_chk (.*);
`default_nettype wire

// [tb/osc_regs_test.sv]
`default_nettype none
`include "osc_defs.vh"
module osc_regs_test;
    timeunit 1ns / 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, ov_pin = 0;
    logic diag_err_pin = 0, sample_valid = 0, pwm_level = 0, sent_level = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, rdat;
    logic [11:0] position = 12'h5A3, temperature = 12'h3C1, amplitude = 12'h2B7;
    wire logic [31:0] prdata;
    wire logic [`OSC_PERIOD_W-1:0] frame_cycles;
    wire logic [11:0] fast_ch1, fast_ch2;
    wire logic [7:0] pwm_force_duty;
    wire logic [1:0] sensor_type;
    wire logic pready, pslverr, sent_sel, normal_mode, burn_in, mem_locked, frame_h1, irq;
    wire logic six_nibbles, pause_pulse, pwm_start_rise, sent_tick, status_err, out_o, out_oe;
    wire logic line;
    int n_mismatch = 0, total_checks = 0, n, i;
    osc_regs #(.CLK_HZ(1000000)) dut (.*);
    osc_rx_model rx (.out_o(out_o), .out_oe(out_oe), .line(line));
    always #10 pclk = ~pclk;
    always @(posedge pclk) {pwm_level, sent_level} <= ~{pwm_level, sent_level};
    task give_verdict;
        if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task x(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (n = 1; n < 9 && pready !== 1'b1; n++) @(posedge pclk);
        {rdat, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        if (pready !== 1'b1) begin
            n_mismatch++;
            give_verdict;
        end
    endtask
    task r(input logic [7:0] a, input logic [31:0] e);
        x(0, a, 0);
        chk(rdat, e);
    endtask
    // Measures the gap to the next tick, bounded so a dead counter cannot hang
    task gap(input int e);
        for (n = 0; n < 200 && sent_tick !== 1'b1; n++) @(posedge pclk);
        @(posedge pclk);
        for (n = 1; n < 200 && sent_tick !== 1'b1; n++) @(posedge pclk);
        chk(n, e);
        if (n >= 200) give_verdict;
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        r(8'h04, 32'h0);
        chk(fast_ch1, 12'hFFE);
        x(1, 8'h04, 32'h7FFF);
        r(8'h04, 32'h7FFF);
        chk({sensor_type, frame_h1, six_nibbles, pwm_start_rise, pause_pulse}, 6'h3E);
        x(1, 8'h04, 32'h0);
        x(1, 8'h00, 32'h30FE);
        r(8'h00, 32'h30FE);
        chk({sent_sel, normal_mode, fast_ch1}, 14'h3000);
        for (i = 0; i < 4; i++) begin
            x(1, 8'h04, (i << 13) | (i << 9) | (i % 2 * 32'h50));
            repeat (2) @(posedge pclk);
            chk({sensor_type, pause_pulse}, {i[1:0], i[0] == 1'b0});
            gap(25 * (i + 1));
        end
        r(8'h18, 32'h0);
        chk(err, 1'b1);
        x(1, 8'h0C, 32'hF);
        sample_valid <= 1'b1;
        r(8'h08, 32'h4);
        chk({irq, fast_ch1}, {1'b1, position});
        x(1, 8'h0C, 32'h0);
        r(8'h08, 32'h4);
        chk(irq, 1'b0);
        x(1, 8'h10, 32'h4);
        r(8'h08, 32'h0);
        diag_err_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        diag_err_pin <= 1'b0;
        repeat (6) @(posedge pclk);
        chk({status_err, burn_in, fast_ch2}, {2'b01, amplitude});
        x(1, 8'h00, 32'h1004);
        repeat (3) @(posedge pclk);
        chk({status_err, fast_ch2}, {1'b1, temperature});
        x(1, 8'h00, 32'h1000);
        repeat (3) @(posedge pclk);
        chk(status_err, 1'b0);
        x(1, 8'h00, 32'h0);
        x(1, 8'h0C, 32'h1);
        ov_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        chk({irq, pwm_force_duty, frame_cycles}, {1'b1, 8'h4B, 20'h003E8});
        x(1, 8'h00, 32'h8);
        repeat (6) @(posedge pclk);
        chk(pwm_force_duty, 8'h0);
        x(1, 8'h00, 32'h80);
        x(1, 8'h04, 32'h80);
        chk({out_oe, line}, 2'b10);
        ov_pin <= 1'b0;
        repeat (8) @(posedge pclk);
        repeat (4) begin
            @(posedge pclk);
            chk({out_o, line}, {1'b0, ~pwm_level});
        end
        x(1, 8'h00, 32'h1);
        x(1, 8'h00, 32'h0);
        r(8'h00, 32'h1);
        give_verdict;
    end
endmodule // osc_regs_test
`default_nettype wire
